// ---- rtl/uart_irq_pkg.sv ----
/*
 Constants, register indices and helpers for the serial interrupt and
 parallel port block. Assumes an AHB-Lite slave with word registers.
*/
package uart_irq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_MODULE_CFG = 12'h700;
    localparam logic [11:0] IDX_COMMAND = 12'h702;
    localparam logic [11:0] IDX_CHANGE = 12'h704;
    localparam logic [11:0] IDX_FLAGS = 12'h715;
    localparam logic [11:0] IDX_PORT_VIEW = 12'h71D;
    localparam logic [11:0] IDX_BIT_SET = 12'h71E;
    localparam logic [11:0] IDX_BIT_RESET = 12'h71F;
    // Flag and enable bit positions
    localparam int FLG_TX_A = 0;
    localparam int FLG_RX_A = 1;
    localparam int FLG_BRK_A = 2;
    localparam int FLG_CLK = 3;
    localparam int FLG_TX_B = 4;
    localparam int FLG_RX_B = 5;
    localparam int FLG_BRK_B = 6;
    localparam int FLG_CTS = 7;
    localparam logic [7:0] MASK_WRITABLE = 8'hF7;
    // Command register bits and the configuration stop bit
    localparam int CMD_BRK_CLR_A = 0;
    localparam int CMD_BRK_CLR_B = 1;
    localparam int CMD_TX_EN_A = 2;
    localparam int CMD_TX_DIS_A = 3;
    localparam int CMD_TX_EN_B = 4;
    localparam int CMD_TX_DIS_B = 5;
    localparam int CFG_STOP_BIT = 7;
    // Pin bit positions
    localparam int PIN_TX_RDY = 6;
    localparam int PIN_RX_RDY = 4;
    localparam int PIN_REQ_B = 1;
    localparam int PIN_REQ_A = 0;
    // Reset values, full FIFO count and OKAY response
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PIN_FN_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] FIFO_FULL_COUNT = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    // Word index of a byte address
    function automatic logic [11:0] word_index(input logic [31:0] addr);
        return addr[13:2];
    endfunction : word_index
endpackage : uart_irq_pkg

// ---- rtl/tx_ctl_if.sv ----
/*
 Command and status bundle between the register block and one
 transmitter holding tracker. Assumes one shared clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface tx_ctl_if;
    logic enable_cmd;
    logic disable_cmd;
    logic hold_write;
    logic shift_take;
    logic ready;
    logic hold_valid;
    modport ctl (output enable_cmd, disable_cmd, hold_write, shift_take,
                 input ready, hold_valid);
    modport hold (input enable_cmd, disable_cmd, hold_write, shift_take,
                  output ready, hold_valid);
endinterface : tx_ctl_if
`default_nettype wire

// ---- rtl/tx_hold_ctl.sv ----
/*
 Transmitter holding register tracker for one channel: ready flag and
 valid character towards the shifter. Assumes single-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module tx_hold_ctl
    import uart_irq_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    tx_ctl_if.hold bus
);
    typedef struct packed {
        logic enabled;
        logic ready;
        logic valid;
    } hold_state_t;
    hold_state_t st_reg, st_next;

    // Disable wins; a write while disabled is dropped
    always_comb begin
        st_next = st_reg;
        if (bus.disable_cmd) begin
            st_next = '0;
        end else if (bus.enable_cmd && !st_reg.enabled) begin
            st_next.enabled = 1'b1;
            st_next.ready = 1'b1;
        end else if (st_reg.enabled) begin
            if (bus.hold_write && st_reg.ready) begin
                st_next.ready = 1'b0;
                st_next.valid = 1'b1;
            end else if (bus.shift_take && st_reg.valid) begin
                st_next.valid = 1'b0;
                st_next.ready = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.ready = st_reg.ready;
    assign bus.hold_valid = st_reg.valid;
endmodule : tx_hold_ctl
`default_nettype wire

// ---- rtl/pin_sync.sv ----
/*
 Three-stage synchroniser for asynchronous level inputs; the value
 moves on only when stages two and three agree. Assumes no clock on pins.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [2:0] pins_in,
    output logic [2:0] level_out
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] level;
    } sync_state_t;
    sync_state_t st_reg, st_next;

    // Stage one feeds stage two only
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < 3; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.level[i] = st_reg.s3[i];
            end
        end
    end

    // Clear-to-send pins idle high (negated), clock-stable pin low (not stable yet)
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg <= {4{3'b011}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;
endmodule : pin_sync
`default_nettype wire

// ---- rtl/uart_irq_port.sv ----
/*
 Interrupt flags, enable mask, clear-to-send input view and output pins
 of a two-channel serial module, as an AHB-Lite slave.
 Assumes transmitter, receiver and baud logic outside on the same clock;
 pins from outside pass a three-stage synchroniser.
*/
`timescale 1ns/1ns
`default_nettype none
module uart_irq_port
    import uart_irq_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic CLEAR_TO_SEND_A_N_IN,
    input wire logic CLEAR_TO_SEND_B_N_IN,
    input wire logic CLOCK_STABLE_IN,
    input wire logic [1:0] RX_FIFO_COUNT_A_IN,
    input wire logic [1:0] RX_FIFO_COUNT_B_IN,
    input wire logic RX_FULL_MODE_A_IN,
    input wire logic RX_FULL_MODE_B_IN,
    input wire logic BREAK_EDGE_A_IN,
    input wire logic BREAK_EDGE_B_IN,
    input wire logic TX_HOLD_WRITE_A_IN,
    input wire logic TX_HOLD_WRITE_B_IN,
    input wire logic TX_SHIFT_TAKE_A_IN,
    input wire logic TX_SHIFT_TAKE_B_IN,
    input wire logic REQ_SEND_ACTIVE_A_IN,
    input wire logic REQ_SEND_ACTIVE_B_IN,
    output logic TX_HOLD_VALID_A_OUT,
    output logic TX_HOLD_VALID_B_OUT,
    output logic IRQ_N_OUT,
    output logic TX_READY_PIN_A_N_OUT,
    output logic RX_READY_PIN_A_N_OUT,
    output logic REQUEST_TO_SEND_A_N_OUT,
    output logic REQUEST_TO_SEND_B_N_OUT
);
    typedef struct packed {
        logic wr_pend;
        logic [11:0] wr_idx;
        logic [31:0] rdata;
        logic [7:0] mask;
        logic [7:0] pin_fn;
        logic [7:0] port;
        logic [7:0] cfg;
        logic brk_a;
        logic brk_b;
        logic rx_a;
        logic rx_b;
        logic clk_flag;
        logic cts_flag;
        logic [1:0] cts_chg;
        logic [1:0] cts_prev;
        logic irq_n;
        logic [3:0] pins_n;
        logic [1:0] hold_valid;
    } top_state_t;
    top_state_t st_reg, st_next;

    logic [2:0] sync_level;
    logic [1:0] cts_now;
    logic clk_stable;
    logic [7:0] flags;
    logic addr_ok;
    logic [11:0] addr_idx;
    logic wr_now;
    logic stop;
    logic [7:0] wbyte;

    tx_ctl_if tx_a ();
    tx_ctl_if tx_b ();

    pin_sync u_sync (
        .clk_in(SYS_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .pins_in({CLOCK_STABLE_IN, CLEAR_TO_SEND_B_N_IN,
                  CLEAR_TO_SEND_A_N_IN}),
        .level_out(sync_level)
    );

    tx_hold_ctl u_tx_a (
        .clk_in(SYS_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .bus(tx_a.hold)
    );

    tx_hold_ctl u_tx_b (
        .clk_in(SYS_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .bus(tx_b.hold)
    );

    // Pin level high means negated, which reads as one
    assign cts_now = sync_level[1:0];
    assign clk_stable = sync_level[2];
    assign stop = st_reg.cfg[CFG_STOP_BIT];
    assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign addr_idx = word_index(HADDR_IN);
    assign wr_now = st_reg.wr_pend;
    assign wbyte = HWDATA_IN[7:0];

    // True flag view; the mask never filters it
    always_comb begin
        flags = 8'h00;
        flags[FLG_TX_A] = tx_a.ready;
        flags[FLG_RX_A] = st_reg.rx_a;
        flags[FLG_BRK_A] = st_reg.brk_a;
        flags[FLG_CLK] = st_reg.clk_flag;
        flags[FLG_TX_B] = tx_b.ready;
        flags[FLG_RX_B] = st_reg.rx_b;
        flags[FLG_BRK_B] = st_reg.brk_b;
        flags[FLG_CTS] = st_reg.cts_flag;
    end

    // Transmitter commands come from the command register
    always_comb begin
        tx_a.enable_cmd = 1'b0;
        tx_a.disable_cmd = 1'b0;
        tx_b.enable_cmd = 1'b0;
        tx_b.disable_cmd = 1'b0;
        if (wr_now && st_reg.wr_idx == IDX_COMMAND && !stop) begin
            tx_a.enable_cmd = wbyte[CMD_TX_EN_A];
            tx_a.disable_cmd = wbyte[CMD_TX_DIS_A];
            tx_b.enable_cmd = wbyte[CMD_TX_EN_B];
            tx_b.disable_cmd = wbyte[CMD_TX_DIS_B];
        end
        tx_a.hold_write = TX_HOLD_WRITE_A_IN;
        tx_a.shift_take = TX_SHIFT_TAKE_A_IN;
        tx_b.hold_write = TX_HOLD_WRITE_B_IN;
        tx_b.shift_take = TX_SHIFT_TAKE_B_IN;
    end

    // Bus, flags and pins; zero wait states, read effects at address phase
    always_comb begin
        logic brk_clr_a;
        logic brk_clr_b;
        logic [1:0] cts_edge;
        logic chg_read;
        logic [7:0] rd;
        brk_clr_a = 1'b0;
        brk_clr_b = 1'b0;
        cts_edge = cts_now ^ st_reg.cts_prev;
        chg_read = 1'b0;
        rd = 8'h00;
        st_next = st_reg;
        st_next.wr_pend = addr_ok && HWRITE_IN;
        st_next.wr_idx = addr_idx;
        st_next.cts_prev = cts_now;

        // Data phase of a write
        if (wr_now) begin
            unique case (st_reg.wr_idx)
                IDX_MODULE_CFG: begin
                    st_next.cfg = wbyte;
                end
                IDX_COMMAND: begin
                    brk_clr_a = wbyte[CMD_BRK_CLR_A] && !stop;
                    brk_clr_b = wbyte[CMD_BRK_CLR_B] && !stop;
                end
                IDX_FLAGS: begin
                    if (!stop) begin
                        st_next.mask = wbyte & MASK_WRITABLE;
                    end
                end
                IDX_PORT_VIEW: begin
                    if (!stop) begin
                        st_next.pin_fn = wbyte;
                    end
                end
                IDX_BIT_SET: begin
                    if (!stop) begin
                        st_next.port = st_reg.port | wbyte;
                    end
                end
                IDX_BIT_RESET: begin
                    if (!stop) begin
                        st_next.port = st_reg.port & ~wbyte;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data registered for the data phase
        if (addr_ok && !HWRITE_IN) begin
            unique case (addr_idx)
                IDX_MODULE_CFG: begin
                    rd = st_reg.cfg;
                end
                IDX_CHANGE: begin
                    if (!stop) begin
                        rd = {2'b00, st_reg.cts_chg, 2'b00, cts_now};
                        chg_read = 1'b1;
                    end
                end
                IDX_FLAGS: begin
                    if (!stop) begin
                        rd = flags;
                    end
                end
                IDX_PORT_VIEW: begin
                    if (!stop) begin
                        rd = {6'h00, cts_now};
                    end
                end
                IDX_BIT_SET: begin
                    rd = st_reg.port;
                end
                default: begin
                    rd = 8'h00;
                end
            endcase
        end
        st_next.rdata = {24'h000000, rd};

        // Break flags: an edge beats a same-cycle clear
        if (brk_clr_a) begin
            st_next.brk_a = 1'b0;
        end
        if (BREAK_EDGE_A_IN) begin
            st_next.brk_a = 1'b1;
        end
        if (brk_clr_b) begin
            st_next.brk_b = 1'b0;
        end
        if (BREAK_EDGE_B_IN) begin
            st_next.brk_b = 1'b1;
        end

        // Receiver flag follows FIFO fill in either mode
        st_next.rx_a = RX_FULL_MODE_A_IN
                       ? (RX_FIFO_COUNT_A_IN == FIFO_FULL_COUNT)
                       : (RX_FIFO_COUNT_A_IN != 2'h0);
        st_next.rx_b = RX_FULL_MODE_B_IN
                       ? (RX_FIFO_COUNT_B_IN == FIFO_FULL_COUNT)
                       : (RX_FIFO_COUNT_B_IN != 2'h0);

        // Once the baud clock is stable the flag stays clear
        if (clk_stable) begin
            st_next.clk_flag = 1'b0;
        end

        // Change flags: a new edge beats the read clear
        if (chg_read) begin
            st_next.cts_chg = 2'b00;
            st_next.cts_flag = 1'b0;
        end
        if (|cts_edge) begin
            st_next.cts_chg = st_next.cts_chg | cts_edge;
            st_next.cts_flag = 1'b1;
        end

        // Clock flag excluded from the request
        st_next.irq_n = ~|(flags & st_reg.mask & MASK_WRITABLE);

        // Only pins 6, 4, 1 and 0 exist; other bits reach nothing
        st_next.pins_n[3] = st_reg.pin_fn[PIN_TX_RDY] ? ~tx_a.ready
                            : ~st_reg.port[PIN_TX_RDY];
        st_next.pins_n[2] = st_reg.pin_fn[PIN_RX_RDY] ? ~st_reg.rx_a
                            : ~st_reg.port[PIN_RX_RDY];
        st_next.pins_n[1] = st_reg.pin_fn[PIN_REQ_B] ? ~REQ_SEND_ACTIVE_B_IN
                            : ~st_reg.port[PIN_REQ_B];
        st_next.pins_n[0] = st_reg.pin_fn[PIN_REQ_A] ? ~REQ_SEND_ACTIVE_A_IN
                            : ~st_reg.port[PIN_REQ_A];
        st_next.hold_valid = {tx_b.hold_valid, tx_a.hold_valid};
    end

    // Mask cleared by reset so nothing requests until enabled
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_reg <= '0;
            st_reg.mask <= MASK_RST;
            st_reg.pin_fn <= PIN_FN_RST;
            st_reg.port <= PORT_RST;
            st_reg.cfg <= CFG_RST;
            st_reg.clk_flag <= 1'b1;
            st_reg.cts_prev <= 2'b11;
            st_reg.irq_n <= 1'b1;
            st_reg.pins_n <= 4'hF;
        end else begin
            st_reg <= st_next;
        end
    end

    // All outputs straight from the state register, except HREADYOUT_OUT and HRESP_OUT, which are constants
    assign HRDATA_OUT = st_reg.rdata;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = HRESP_OKAY;
    assign IRQ_N_OUT = st_reg.irq_n;
    assign TX_READY_PIN_A_N_OUT = st_reg.pins_n[3];
    assign RX_READY_PIN_A_N_OUT = st_reg.pins_n[2];
    assign REQUEST_TO_SEND_B_N_OUT = st_reg.pins_n[1];
    assign REQUEST_TO_SEND_A_N_OUT = st_reg.pins_n[0];
    assign TX_HOLD_VALID_A_OUT = st_reg.hold_valid[0];
    assign TX_HOLD_VALID_B_OUT = st_reg.hold_valid[1];

    // Checks on the register and pin behaviour
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    a_clock_flag_silent: assert property (
        (flags == 8'h08) |=> IRQ_N_OUT)
        else $error("clock flag raised the interrupt");
    a_irq_masked: assert property (
        ((flags & st_reg.mask) != 8'h00) |=> !IRQ_N_OUT)
        else $error("enabled flag did not raise interrupt");
    a_mask_reserved: assert property (st_reg.mask[FLG_CLK] == 1'b0)
        else $error("reserved enable bit set");
    // Set by an edge, then held until a clear command gets through
    a_break_set_hold: assert property (
        (BREAK_EDGE_A_IN || (st_reg.brk_a && !(wr_now && !stop
            && st_reg.wr_idx == IDX_COMMAND && wbyte[CMD_BRK_CLR_A])))
        |=> st_reg.brk_a)
        else $error("break change flag not held");
    a_stop_blocks: assert property (
        (wr_now && stop && st_reg.wr_idx == IDX_FLAGS)
        |=> $stable(st_reg.mask))
        else $error("mask written while stopped");
    a_pin6_ready: assert property (
        (st_reg.pin_fn[PIN_TX_RDY] && tx_a.ready)
        |=> !TX_READY_PIN_A_N_OUT)
        else $error("ready pin not low when ready");
    a_bit_set: assert property (
        (wr_now && !stop && st_reg.wr_idx == IDX_BIT_SET)
        |=> ((st_reg.port & $past(wbyte)) == $past(wbyte)))
        else $error("set command missed a bit");
    a_bit_reset: assert property (
        (wr_now && !stop && st_reg.wr_idx == IDX_BIT_RESET)
        |=> ((st_reg.port & $past(wbyte)) == 8'h00))
        else $error("reset command missed a bit");
    a_rx_full: assert property (
        (RX_FULL_MODE_A_IN && RX_FIFO_COUNT_A_IN == 2'h3)
        |=> st_reg.rx_a ##1 !RX_READY_PIN_A_N_OUT [*1]
        or !st_reg.pin_fn[PIN_RX_RDY])
        else $error("full flag not set");

    c_irq_raised: cover property ($fell(IRQ_N_OUT));
    c_break_cleared: cover property ($fell(st_reg.brk_a));
    c_port_toggle: cover property ($rose(st_reg.port[0]) ##[1:20]
                                   $fell(st_reg.port[0]));
endmodule : uart_irq_port
`default_nettype wire

// ---- sim/ahb_host_model.sv ----
/*
 Bus master standing in for the host core: single word transfers only.
 Assumes one slave whose ready output is fed back on hready_in.
*/
`timescale 1ns/1ns
`default_nettype none
module ahb_host_model (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    int stalls = 0;
    // Idle bus from time zero
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h00000000;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h00000000;
    end
    // One transfer; waits are bounded so a dead slave cannot hang the run
    task automatic xfer(input logic wr, input logic [11:0] idx,
                        input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        hsel_out <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out <= {18'h00000, idx, 2'h0};
        hwrite_out <= wr;
        do begin
            @(posedge clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 16);
        if (hready_in !== 1'b1) stalls++;
        hsel_out <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= {24'h000000, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 32);
        q = hrdata_in[7:0];
        if (hready_in !== 1'b1) stalls++;
    endtask : xfer
endmodule : ahb_host_model
`default_nettype wire

// ---- sim/uart_irq_port_test.sv ----
/*
 Self-checking bench for the serial interrupt and port block.
 Assumes the slave answers with zero wait states; expectations are
 worked out here from the flag, mask and port definitions.
*/
`timescale 1ns/1ns
`default_nettype none
module uart_irq_port_test;
    import uart_irq_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, cts_a_n = 1'b1, cts_b_n = 1'b1;
    logic stable = 1'b0, full_a = 1'b0, full_b = 1'b0, brk_a = 1'b0;
    logic hw_a = 1'b0, take_a = 1'b0, ra = 1'b0, rb = 1'b0, hw_b = 1'b0;
    logic [1:0] cnt_a = 2'h0, cnt_b = 2'h0, htrans;
    logic hsel, hwrite, hready, hresp, val_a, val_b, irq_n, p6, p4, p1, p0;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] q, port, fn, m, e;
    int mismatches = 0, checks_done = 0;

    // 50 ns clock
    initial forever #25 clk = ~clk;

    ahb_host_model i_host (.clk_in(clk), .hready_in(hready),
        .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
        .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hwdata_out(hwdata));
    uart_irq_port i_uart_irq_port (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n),
        .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .CLEAR_TO_SEND_A_N_IN(cts_a_n),
        .CLEAR_TO_SEND_B_N_IN(cts_b_n), .CLOCK_STABLE_IN(stable),
        .RX_FIFO_COUNT_A_IN(cnt_a), .RX_FIFO_COUNT_B_IN(cnt_b),
        .RX_FULL_MODE_A_IN(full_a), .RX_FULL_MODE_B_IN(full_b),
        .BREAK_EDGE_A_IN(brk_a), .BREAK_EDGE_B_IN(1'b0),
        .TX_HOLD_WRITE_A_IN(hw_a), .TX_HOLD_WRITE_B_IN(hw_b),
        .TX_SHIFT_TAKE_A_IN(take_a), .TX_SHIFT_TAKE_B_IN(1'b0),
        .REQ_SEND_ACTIVE_A_IN(ra), .REQ_SEND_ACTIVE_B_IN(rb),
        .TX_HOLD_VALID_A_OUT(val_a), .TX_HOLD_VALID_B_OUT(val_b),
        .IRQ_N_OUT(irq_n), .TX_READY_PIN_A_N_OUT(p6),
        .RX_READY_PIN_A_N_OUT(p4), .REQUEST_TO_SEND_A_N_OUT(p0),
        .REQUEST_TO_SEND_B_N_OUT(p1));

    // Counted comparison, four-state exact
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        i_host.xfer(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
        i_host.xfer(1'b0, idx, 8'h00, q);
        check(q, exp);
        check(hresp, HRESP_OKAY);
    endtask : rd
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n
    // Receiver flag meaning depends on mode: any waiting or all three
    function automatic logic rx_flag(input logic [1:0] c, input logic f);
        return f ? (c == 2'h3) : (c != 2'h0);
    endfunction : rx_flag
    // Active-low pins: function source or inverted port bit
    function automatic logic [3:0] pins(input logic [7:0] f,
        input logic [7:0] p, input logic rxf, input logic a, input logic b);
        return {f[6] ? 1'b1 : ~p[6], f[4] ? ~rxf : ~p[4],
                f[1] ? ~b : ~p[1], f[0] ? ~a : ~p[0]};
    endfunction : pins
    task automatic end_sim;
        mismatches += i_host.stalls;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    initial begin
        void'($urandom(36980));
        wait_n(20);
        arst_n <= 1'b1;
        wait_n(6);
        i_host.xfer(1'b0, IDX_CHANGE, 8'h00, q);
        rd(IDX_FLAGS, 8'h08);
        check(irq_n, 1'b1);
        wr(IDX_FLAGS, 8'h08);
        wait_n(3);
        check(irq_n, 1'b1);
        stable <= 1'b1;
        wait_n(6);
        rd(IDX_FLAGS, 8'h00);
        // Transmitter A: enable, load, shift, disable, load while off
        wr(IDX_PORT_VIEW, 8'h40);
        wr(IDX_FLAGS, 8'h01);
        wr(IDX_COMMAND, 8'h04);
        wait_n(3);
        rd(IDX_FLAGS, 8'h01);
        check({irq_n, p6}, 2'b00);
        hw_a <= 1'b1;
        wait_n(1);
        hw_a <= 1'b0;
        wait_n(3);
        check({val_a, irq_n, p6}, 3'b111);
        take_a <= 1'b1;
        wait_n(1);
        take_a <= 1'b0;
        wait_n(3);
        check(val_a, 1'b0);
        rd(IDX_FLAGS, 8'h01);
        wr(IDX_COMMAND, 8'h08);
        hw_a <= 1'b1;
        wait_n(1);
        hw_a <= 1'b0;
        wait_n(3);
        check(val_a, 1'b0);
        rd(IDX_FLAGS, 8'h00);
        // Transmitter B: enable, load, disable drops the held character
        wr(IDX_COMMAND, 8'h10);
        rd(IDX_FLAGS, 8'h10);
        hw_b <= 1'b1;
        wait_n(1);
        hw_b <= 1'b0;
        wait_n(3);
        check(val_b, 1'b1);
        wr(IDX_COMMAND, 8'h20);
        wait_n(3);
        check(val_b, 1'b0);
        rd(IDX_FLAGS, 8'h00);
        // Break A held until its clear command
        brk_a <= 1'b1;
        wait_n(1);
        brk_a <= 1'b0;
        wait_n(8);
        rd(IDX_FLAGS, 8'h04);
        wr(IDX_COMMAND, 8'h01);
        rd(IDX_FLAGS, 8'h00);
        // Random mask and FIFO levels, full-mode corners first: A full, B one short of full
        for (int i = 0; i < 24; i++) begin
            m = $urandom;
            cnt_a <= (i < 2) ? 2'h3 : 2'($urandom);
            cnt_b <= (i < 2) ? 2'h2 : 2'($urandom);
            full_a <= (i == 0) | 1'($urandom);
            full_b <= (i == 1) | 1'($urandom);
            wr(IDX_FLAGS, m);
            wait_n(3);
            e = {2'b00, rx_flag(cnt_b, full_b), 3'b000,
                 rx_flag(cnt_a, full_a), 1'b0};
            rd(IDX_FLAGS, e);
            check(irq_n, ~|(e & m & 8'hF7));
        end
        // Port set and reset commands against pin functions
        port = PORT_RST;
        for (int i = 0; i < 20; i++) begin
            e = $urandom;
            fn = $urandom;
            ra <= 1'($urandom);
            rb <= 1'($urandom);
            wr(IDX_PORT_VIEW, fn);
            if (i % 2 == 0) wr(IDX_BIT_SET, e);
            else wr(IDX_BIT_RESET, e);
            port = (i % 2 == 0) ? (port | e) : (port & ~e);
            wait_n(3);
            rd(IDX_BIT_SET, port);
            check({p6, p4, p1, p0}, pins(fn, port,
                  rx_flag(cnt_a, full_a), ra, rb));
        end
        // Clear-to-send view reads the live level; change bits hold the edge until read
        cts_a_n <= 1'b0;
        wait_n(6);
        i_host.xfer(1'b0, IDX_PORT_VIEW, 8'h00, q);
        check(q[1:0], 2'b10);
        i_host.xfer(1'b0, IDX_CHANGE, 8'h00, q);
        check(q, 8'h12);
        // Stop bit blocks mask and port writes, flag and view reads
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_MODULE_CFG, 8'h80);
        wr(IDX_FLAGS, 8'hFF);
        wr(IDX_BIT_SET, 8'hFF);
        brk_a <= 1'b1;
        wait_n(1);
        brk_a <= 1'b0;
        wait_n(3);
        rd(IDX_FLAGS, 8'h00);
        rd(IDX_PORT_VIEW, 8'h00);
        check(irq_n, 1'b1);
        wr(IDX_MODULE_CFG, 8'h00);
        rd(IDX_BIT_SET, port);
        // Enabled break raises the request; a reset in mid-run clears mask
        wr(IDX_FLAGS, 8'h04);
        wait_n(3);
        check(irq_n, 1'b0);
        arst_n <= 1'b0;
        wait_n(2);
        arst_n <= 1'b1;
        wait_n(2);
        brk_a <= 1'b1;
        wait_n(1);
        brk_a <= 1'b0;
        wait_n(3);
        check(irq_n, 1'b1);
        rd(12'h7FF, 8'h00);
        end_sim();
    end
endmodule : uart_irq_port_test
`default_nettype wire
